//--- cst_pkg.sv
// cst_pkg: constants for the check source test sequencer
// assumes a 20 MHz system clock; long counts are module parameters
package cst_pkg;
  localparam int CST_CLK_HZ = 20000000;
  // automatic test interval, in tenths of a minute
  localparam int CST_AUTO_TENTHS_MIN = 171;
  localparam longint CST_AUTO_CYCLES =
    longint'(CST_AUTO_TENTHS_MIN) * 6 * longint'(CST_CLK_HZ);
  // mute window in seconds
  localparam int CST_MUTE_S = 6;
  localparam longint CST_MUTE_CYCLES =
    longint'(CST_MUTE_S) * longint'(CST_CLK_HZ);
  // ramp start pulse width in microseconds
  localparam int CST_START_US = 10;
  localparam int CST_START_CYCLES = CST_START_US * (CST_CLK_HZ / 1000000);
  // enable delay and width in milliseconds
  localparam int CST_EN_DELAY_MS = 3000;
  localparam longint CST_EN_DELAY_CYCLES =
    longint'(CST_EN_DELAY_MS) * longint'(CST_CLK_HZ / 1000);
  localparam int CST_EN_WIDTH_MS = 100;
  localparam longint CST_EN_WIDTH_CYCLES =
    longint'(CST_EN_WIDTH_MS) * longint'(CST_CLK_HZ / 1000);
  localparam int CST_CNT_W = 35;
  localparam logic CST_LATCH_PASS = 1'b0;
  localparam logic CST_LATCH_FAIL = 1'b1;
  typedef enum logic [1:0] {
    CST_IDLE = 2'b00,
    CST_DELAY = 2'b01,
    CST_ENABLE = 2'b10,
    CST_WAIT = 2'b11
  } cst_state_type;
endpackage

//--- cst_oneshot_if.sv
// cst_oneshot_if: trigger and pulse of a counter one-shot
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface cst_oneshot_if;
  logic trig;
  logic active;
  modport owner (output trig, input active);
  modport shot (input trig, output active);
endinterface

//--- cst_oneshot.sv
// cst_oneshot: non-retriggerable counter one-shot
// assumes trig is synchronous to clk
`timescale 1ns/1ps
module cst_oneshot #(
  parameter longint WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // trigger and pulse
  cst_oneshot_if.shot os
);
  import cst_pkg::*;
  logic [CST_CNT_W-1:0] cnt_reg;
  logic active_reg;
  assign os.active = active_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      active_reg <= 1'b0;
    end else if (!active_reg) begin
      if (os.trig) begin
        cnt_reg <= CST_CNT_W'(WIDTH - 1);
        active_reg <= 1'b1;
      end
    end else if (cnt_reg == '0) begin
      active_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

//--- cst_sequencer.sv
// cst_sequencer: self-check test sequencer of the radiation monitor
// assumes push buttons and comparators are asynchronous pins
`timescale 1ns/1ps
// Contract
// - button closing edge gives one start trigger
// - presses ignored while a test runs
// - accepted start fires ramp start pulse
// - manual start restarts auto timer; expiry autostarts
// - each start mutes alarms six seconds
// - mute suppresses alert and high alarms
// - channel test overrides muting
// - mute holds fail comparator non-alarm
// - mute feeds back, blocking button jitter
// - sequencer delay counter from start gives enable
// - enable delayed into settled ramp
// - enable active low; latch holds otherwise
// - latch is gated set/reset flip-flop
// - monitor rests high, low means pass
// - enable samples monitor; high sets fail
// - latch low pass, high fail
// - fail kills safe lamp and relays
// - low fail/safe drive extinguishes lamp
// - lamp same for manual or automatic
// - channel lamp needs both alarms operated
module cst_sequencer
  import cst_pkg::*;
#(
  parameter longint AUTO_CYCLES = cst_pkg::CST_AUTO_CYCLES,
  parameter longint MUTE_CYCLES = cst_pkg::CST_MUTE_CYCLES,
  parameter longint EN_DELAY_CYCLES = cst_pkg::CST_EN_DELAY_CYCLES,
  parameter longint EN_WIDTH_CYCLES = cst_pkg::CST_EN_WIDTH_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operator buttons, active while pressed
  input wire logic check_source_test_btn,
  input wire logic channel_test_btn,
  // alarm comparators and monitoring input
  input wire logic alert_trip,
  input wire logic high_trip,
  input wire logic monitor_fail,
  input wire logic hv_present,
  // test stimulus and timing outputs
  output logic ramp_start,
  output logic mute,
  output logic latch_enable_n,
  output cst_pkg::cst_state_type test_state,
  // result and alarm drives
  output logic fail_latch,
  output logic safe_lamp,
  output logic relay_energize,
  output logic alert_alarm,
  output logic high_alarm,
  output logic channel_lamp
);
  import cst_pkg::*;

  // two-stage synchronisers for all pins
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] pins;
  assign pins = {check_source_test_btn, channel_test_btn, alert_trip,
                 high_trip, monitor_fail, hv_present};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // idle pin levels, so release fakes neither a press nor a fail
      sync1_reg <= 6'h03;
      sync2_reg <= 6'h03;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  logic btn_s, chan_s, alert_s, high_s, mon_s, hv_s;
  assign {btn_s, chan_s, alert_s, high_s, mon_s, hv_s} = sync2_reg;

  // edge detect on button
  logic btn_prev_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) btn_prev_reg <= 1'b0;
    else btn_prev_reg <= btn_s;
  end
  logic btn_edge;
  assign btn_edge = btn_s && !btn_prev_reg;

  // one-shots
  cst_oneshot_if mute_if ();
  cst_oneshot_if start_if ();
  logic busy;
  logic manual_start;
  logic auto_start;
  logic test_start;
  logic auto_expire;
  cst_state_type state_reg;
  cst_state_type state_next;
  // mute output feeds back so bounce cannot retrigger
  assign busy = mute_if.active || state_reg != CST_IDLE;
  assign manual_start = btn_edge && !busy;
  assign auto_start = auto_expire && !busy;
  assign test_start = manual_start || auto_start;
  assign mute_if.trig = test_start;
  assign start_if.trig = test_start;

  cst_oneshot #(.WIDTH(MUTE_CYCLES)) u_mute (
    .clk(clk),
    .rst(rst),
    .os(mute_if)
  );
  cst_oneshot #(.WIDTH(longint'(CST_START_CYCLES))) u_start (
    .clk(clk),
    .rst(rst),
    .os(start_if)
  );

  // automatic interval timer
  logic [CST_CNT_W-1:0] auto_cnt_reg;
  assign auto_expire = auto_cnt_reg == CST_CNT_W'(AUTO_CYCLES - 1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) auto_cnt_reg <= '0;
    else if (test_start || auto_expire) auto_cnt_reg <= '0;
    else auto_cnt_reg <= auto_cnt_reg + 1'b1;
  end

  // enable sequencer: delay, then active-low enable window
  logic [CST_CNT_W-1:0] seq_cnt_reg;
  logic seq_done;
  assign seq_done = seq_cnt_reg == '0;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CST_IDLE: if (test_start) state_next = CST_DELAY;
      CST_DELAY: if (seq_done) state_next = CST_ENABLE;
      CST_ENABLE: if (seq_done) state_next = CST_WAIT;
      CST_WAIT: if (!mute_if.active) state_next = CST_IDLE;
      default: state_next = CST_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_reg <= CST_IDLE;
    else state_reg <= state_next;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_cnt_reg <= '0;
    end else if (state_reg == CST_IDLE && test_start) begin
      seq_cnt_reg <= CST_CNT_W'(EN_DELAY_CYCLES - 1);
    end else if (state_reg == CST_DELAY && seq_done) begin
      seq_cnt_reg <= CST_CNT_W'(EN_WIDTH_CYCLES - 1);
    end else if (!seq_done) begin
      seq_cnt_reg <= seq_cnt_reg - 1'b1;
    end
  end
  logic enable_n;
  assign enable_n = !(state_reg == CST_ENABLE);

  // pass/fail latch: gated set/reset, monitor high = fail
  always_ff @(posedge clk or posedge rst) begin
    if (rst) fail_latch <= CST_LATCH_PASS;
    else if (!enable_n)
      fail_latch <= mon_s ? CST_LATCH_FAIL : CST_LATCH_PASS;
  end

  // fail comparator: latch fail or lost high voltage, held safe by mute
  logic fail_cmp;
  assign fail_cmp = !mute_if.active && (fail_latch || !hv_s);

  // alarm gating, channel test defeats muting
  logic mute_eff;
  assign mute_eff = mute_if.active && !chan_s;
  // test timing outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_start <= 1'b0;
      mute <= 1'b0;
      latch_enable_n <= 1'b1;
      test_state <= CST_IDLE;
    end else begin
      ramp_start <= start_if.active;
      mute <= mute_eff;
      latch_enable_n <= enable_n;
      test_state <= state_reg;
    end
  end

  // lamp and relay share one source, so they never disagree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      safe_lamp <= 1'b1;
      relay_energize <= 1'b1;
    end else begin
      safe_lamp <= !fail_cmp;
      relay_energize <= !fail_cmp;
    end
  end

  // alarm outputs, gated by the effective mute
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alert_alarm <= 1'b0;
      high_alarm <= 1'b0;
    end else begin
      alert_alarm <= alert_s && !mute_eff;
      high_alarm <= high_s && !mute_eff;
    end
  end

  // one cycle behind the registered alarms
  always_ff @(posedge clk or posedge rst) begin
    if (rst) channel_lamp <= 1'b0;
    else channel_lamp <= alert_alarm && high_alarm;
  end

  // checks
  sequence s_start;
    test_start;
  endsequence
  sequence s_enable_later;
    ##1 (state_reg == CST_DELAY) ##1 enable_n;
  endsequence
  AST_EDGE_ONLY: assert property (@(posedge clk) disable iff (rst)
    manual_start |=> !manual_start)
    else $error("manual start lasted two cycles");
  AST_NO_DOUBLE: assert property (@(posedge clk) disable iff (rst)
    busy |-> !test_start)
    else $error("test started while busy");
  AST_MUTE_SETS: assert property (@(posedge clk) disable iff (rst)
    s_start |=> mute_if.active)
    else $error("mute one-shot did not fire");
  AST_ENABLE_DELAY: assert property (@(posedge clk) disable iff (rst)
    s_start |-> s_enable_later)
    else $error("enable not delayed after start");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
    enable_n |=> $stable(fail_latch))
    else $error("latch moved without enable");
  AST_LATCH_FAIL: assert property (@(posedge clk) disable iff (rst)
    (!enable_n && mon_s) |=> fail_latch)
    else $error("high monitor did not set fail");
  AST_MUTE_ALARM: assert property (@(posedge clk) disable iff (rst)
    mute_eff |=> !alert_alarm && !high_alarm)
    else $error("alarm during mute");
  AST_CHAN_OVR: assert property (@(posedge clk) disable iff (rst)
    (chan_s && alert_s) |=> alert_alarm)
    else $error("channel test alarm muted");
  AST_HOLD_SAFE: assert property (@(posedge clk) disable iff (rst)
    mute_if.active |=> relay_energize)
    else $error("fail during mute window");
  AST_CHAN_LAMP: assert property (@(posedge clk) disable iff (rst)
    channel_lamp |-> $past(alert_alarm) && $past(high_alarm))
    else $error("channel lamp without both alarms");

  // helper counters for the timed checks, read by assertions only
  logic [CST_CNT_W-1:0] mute_len_reg;
  logic [CST_CNT_W-1:0] en_len_reg;
  logic [CST_CNT_W-1:0] start_age_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) mute_len_reg <= '0;
    else if (!mute_if.active) mute_len_reg <= '0;
    else mute_len_reg <= mute_len_reg + 1'b1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) en_len_reg <= '0;
    else if (enable_n) en_len_reg <= '0;
    else en_len_reg <= en_len_reg + 1'b1;
  end
  // saturates, so a long idle spell cannot wrap into a false match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) start_age_reg <= '0;
    else if (test_start) start_age_reg <= '0;
    else if (start_age_reg != '1) start_age_reg <= start_age_reg + 1'b1;
  end

  sequence s_mute_over;
    $fell(mute_if.active);
  endsequence
  sequence s_enable_opens;
    $fell(enable_n);
  endsequence
  sequence s_enable_closes;
    $rose(enable_n);
  endsequence

  // timed windows, the first three measured by the helper counters
  AST_MUTE_WIDTH: assert property (@(posedge clk) disable iff (rst)
    s_mute_over |-> mute_len_reg == CST_CNT_W'(MUTE_CYCLES))
    else $error("mute window has the wrong length");
  AST_EN_DELAY_LEN: assert property (@(posedge clk) disable iff (rst)
    s_enable_opens |-> start_age_reg == CST_CNT_W'(EN_DELAY_CYCLES))
    else $error("enable delay has the wrong length");
  AST_EN_WIDTH: assert property (@(posedge clk) disable iff (rst)
    s_enable_closes |-> en_len_reg == CST_CNT_W'(EN_WIDTH_CYCLES))
    else $error("enable pulse has the wrong width");
  AST_EN_IN_MUTE: assert property (@(posedge clk) disable iff (rst)
    !enable_n |-> mute_if.active)
    else $error("enable outside the mute window");
  AST_WAIT_IDLE: assert property (@(posedge clk) disable iff (rst)
    (state_reg == CST_WAIT && !mute_if.active) |=> state_reg == CST_IDLE)
    else $error("sequencer did not return to idle");

  // start path
  AST_RAMP_FIRES: assert property (@(posedge clk) disable iff (rst)
    s_start |=> start_if.active)
    else $error("ramp one-shot did not fire");
  AST_RAMP_OUT: assert property (@(posedge clk) disable iff (rst)
    start_if.active |=> ramp_start)
    else $error("ramp start output missing");
  AST_AUTO_RESTART: assert property (@(posedge clk) disable iff (rst)
    s_start |=> auto_cnt_reg == '0)
    else $error("interval timer not restarted");
  AST_AUTO_LAUNCH: assert property (@(posedge clk) disable iff (rst)
    (auto_expire && !busy) |=> mute_if.active)
    else $error("interval expiry did not start a test");
  AST_BOUNCE_BLOCK: assert property (@(posedge clk) disable iff (rst)
    (mute_if.active && btn_edge) |-> !test_start)
    else $error("button bounce retriggered the test");

  // latch and result drives
  AST_LATCH_PASS: assert property (@(posedge clk) disable iff (rst)
    (!enable_n && !mon_s) |=> !fail_latch)
    else $error("low monitor did not give pass");
  AST_EN_OUT: assert property (@(posedge clk) disable iff (rst)
    !latch_enable_n |-> !$past(enable_n))
    else $error("enable output without internal enable");
  AST_FAIL_DROPS: assert property (@(posedge clk) disable iff (rst)
    (!mute_if.active && fail_latch) |=> !safe_lamp && !relay_energize)
    else $error("fail did not drop lamp and relay");
  AST_PASS_LIT: assert property (@(posedge clk) disable iff (rst)
    (!mute_if.active && !fail_latch && hv_s) |=> safe_lamp)
    else $error("pass did not keep the lamp lit");
  AST_HV_HELD: assert property (@(posedge clk) disable iff (rst)
    (mute_if.active && !hv_s) |=> safe_lamp && relay_energize)
    else $error("lost high voltage failed during mute");

  // alarms and muting
  AST_MUTE_OUT: assert property (@(posedge clk) disable iff (rst)
    (mute_if.active && !chan_s) |=> mute)
    else $error("mute output missing during test");
  AST_CHAN_UNMUTE: assert property (@(posedge clk) disable iff (rst)
    chan_s |=> !mute)
    else $error("mute output during channel test");
  AST_HIGH_OVR: assert property (@(posedge clk) disable iff (rst)
    (chan_s && high_s) |=> high_alarm)
    else $error("channel test high alarm muted");
  AST_ALARM_FREE: assert property (@(posedge clk) disable iff (rst)
    (!mute_eff && alert_s) |=> alert_alarm)
    else $error("alert alarm blocked without mute");
  AST_HIGH_FREE: assert property (@(posedge clk) disable iff (rst)
    (!mute_eff && high_s) |=> high_alarm)
    else $error("high alarm blocked without mute");
endmodule

//--- cst_far_model.sv
// cst_far_model: detector comparator and high-voltage source
// assumes mute marks a running self-check test
`timescale 1ns/1ps
module cst_far_model (
  // test marker
  input wire logic mute,
  // scenario controls
  input wire logic good,
  input wire logic hv_ok,
  // detector side
  output logic monitor_fail,
  output logic hv_present
);
  // rests at fail, drops to pass only inside a good test
  assign monitor_fail = !(mute && good);
  assign hv_present = hv_ok;
endmodule

//--- testbench.sv
// testbench: self-check sequencer bench with shortened counts
// assumes the far model drives monitor and high-voltage inputs
`timescale 1ns/1ps
module testbench;
  import cst_pkg::*;
  localparam longint AC = 200, MC = 100, DC = 40, WC = 5;
  logic clk = 0, rst = 1, btn = 0, chan = 0, alert = 0, high = 0;
  logic good = 1, hv_ok = 1, mf, hv, ramp_start, mute, en_n, fl, lamp;
  logic relay, aa, ha, cl;
  cst_state_type st;
  int num_errors = 0, tests_run = 0, cyc = 0, t0, t1, w, d, ew, leak;
  logic ramp;
  // alert, high, then expected alert, high, channel lamp
  logic [4:0] rows [4] = '{5'b00000, 5'b10100, 5'b01010, 5'b11111};
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  cst_sequencer #(.AUTO_CYCLES(AC), .MUTE_CYCLES(MC),
    .EN_DELAY_CYCLES(DC), .EN_WIDTH_CYCLES(WC)) i_cst_sequencer (
    .clk(clk), .rst(rst), .check_source_test_btn(btn),
    .channel_test_btn(chan), .alert_trip(alert), .high_trip(high),
    .monitor_fail(mf), .hv_present(hv), .ramp_start(ramp_start),
    .mute(mute), .latch_enable_n(en_n), .test_state(st),
    .fail_latch(fl), .safe_lamp(lamp), .relay_energize(relay),
    .alert_alarm(aa), .high_alarm(ha), .channel_lamp(cl));
  cst_far_model i_cst_far_model (.mute(mute), .good(good),
    .hv_ok(hv_ok), .monitor_fail(mf), .hv_present(hv));
  task automatic chk(string n, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_n(string n, int e, int g);
    tests_run++;
    if (g != e) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  // trips and high-voltage loss are applied inside the mute window
  task automatic run_test(bit rep);
    for (w = 0; w < 300 && mute !== 1; w++) tick(1);
    if (mute !== 1) begin
      chk("mute start", 1, mute);
      report_and_stop;
    end
    t0 = cyc;
    ramp = ramp_start;
    w = 0; d = 0; ew = 0; leak = 0;
    while (mute === 1 && w < 200) begin
      if (en_n === 0 && ew++ == 0) d = w;
      if (aa !== 0 || ha !== 0 || (w > 4 && lamp !== 1)) leak++;
      {alert, high, hv_ok} = (w < 60) ? 3'b110 : 3'b001;
      if (rep && w == 20) btn = 0;
      if (rep && w == 22) btn = 1;
      w++;
      tick(1);
    end
    {alert, high, hv_ok} = 3'b001;
    chk_n("mute width", MC, w);
    chk("ramp_start", 1, ramp);
    chk("enable delay", 1, d >= DC - 2 && d <= DC + 1);
    chk_n("enable width", WC, ew);
    chk_n("alarm leak", 0, leak);
  endtask
  initial begin
    tick(2);
    chk("fail_latch reset", 0, fl);
    chk("enable reset", 1, en_n);
    chk("safe_lamp reset", 1, lamp);
    chk("mute reset", 0, mute);
    tick(2);
    rst = 0;
    foreach (rows[k]) begin
      {alert, high} = rows[k][4:3];
      tick(5);
      chk("alert_alarm", rows[k][2], aa);
      chk("high_alarm", rows[k][1], ha);
      chk("channel_lamp", rows[k][0], cl);
    end
    chk("idle after reset", 1, st === CST_IDLE);
    {alert, high} = 2'b00;
    btn = 1;
    run_test(1);
    tick(10);
    chk("idle after test", 1, st === CST_IDLE);
    chk("fail_latch pass", 0, fl);
    btn = 0;
    good = 0;
    tick(2);
    btn = 1;
    run_test(0);
    t1 = t0;
    tick(3);
    btn = 0;
    chk("fail_latch fail", 1, fl);
    chk("safe_lamp fail", 0, lamp);
    chk("relay fail", 0, relay);
    good = 1;
    run_test(0);
    chk("auto interval", 1, t0 - t1 >= AC - 3 && t0 - t1 <= AC + 3);
    tick(3);
    chk("fail_latch auto", 0, fl);
    chk("safe_lamp auto", 1, lamp);
    chk("relay auto", 1, relay);
    {chan, alert, high, btn} = 4'hF;
    tick(12);
    chk("test running", 1, st !== CST_IDLE);
    chk("mute override", 0, mute);
    chk("alert under test", 1, aa);
    chk("high under test", 1, ha);
    chk("channel_lamp test", 1, cl);
    {chan, alert, high, btn} = 4'h0;
    tick(150);
    report_and_stop;
  end
endmodule
